// ==== testbench/dpmc_mem_model.sv ====
// Behavioural left port of the two-port mailbox memory.
// Assumes pins are sampled on clk; far side is stood in by bench inputs.
`timescale 1ns/1ps
`include "dpmc_consts.svh"
module dpmc_mem_model (
    input  wire logic                     clk,
    input  wire dpmc_pkg::dpmc_port_out_s port_o,
    input  wire logic [15:0]              data_o,
    input  wire logic [15:0]              data_oe,
    input  wire logic                     busy_in_n,
    input  wire logic                     far_mbox_wr,
    input  wire logic [7:0]               far_req_n,
    output dpmc_pkg::dpmc_port_in_s       port_i,
    output logic      [15:0]              data_i,
    output logic                          far_irq_n
);
    import dpmc_pkg::*;
    logic [15:0] mem [0:16383];
    logic [7:0]  own_req_n = 8'hFF;
    logic [7:0]  own_has = 8'h00;
    logic        irq_n = 1'h1;
    logic        sem_rd_q = 1'h0;
    logic        mem_rd, mem_wr, sem_rd, sem_wr;
    logic [2:0]  fl;
    // Decode; no select means standby, busy low gates array writes
    assign fl = port_o.addr[2:0];
    assign mem_rd = !port_o.chip_en_n && !port_o.out_en_n;
    assign mem_wr = !port_o.chip_en_n && !port_o.rd_wr_n && busy_in_n;
    assign sem_rd = !port_o.flag_space_select_n && !port_o.out_en_n;
    assign sem_wr = !port_o.flag_space_select_n && !port_o.rd_wr_n;
    assign port_i = '{busy_n: busy_in_n, mailbox_irq_n: irq_n};
    initial far_irq_n = 1'h1;
    initial data_i = 16'h5A5A;
    // Array, mailboxes and flags; far side stalls this port through busy_in_n, whose low level drops array writes
    always @(posedge clk) begin
        if (mem_wr && !port_o.high_byte_select_n)
            mem[port_o.addr][15:8] <= data_o[15:8];
        if (mem_wr && !port_o.low_byte_select_n)
            mem[port_o.addr][7:0] <= data_o[7:0];
        if (mem_wr && port_o.addr == `DPMC_MBOX_RIGHT)
            far_irq_n <= 1'h0;
        if (far_mbox_wr)
            irq_n <= 1'h0;
        else if (mem_rd && port_o.addr == `DPMC_MBOX_LEFT)
            irq_n <= 1'h1;
        if (sem_wr)
            own_req_n[fl] <= data_o[0];
        own_has <= ~own_req_n & (own_has | far_req_n);
        sem_rd_q <= sem_rd;
        // Released bus toggles so a stale value never looks valid
        if (mem_rd)
            data_i <= mem[port_o.addr];
        else if (sem_rd && !sem_rd_q)
            data_i <= {16{~own_has[fl]}};
        else if (!sem_rd)
            data_i <= ~data_i;
    end
endmodule

// ==== testbench/dpmc_port_ctrl_assertions.sv ====
// Checker for the mailbox port controller: APB answer and pin timing.
// Assumes it is bound onto dpmc_port_ctrl and sees only its ports.
`timescale 1ns/1ps
module dpmc_port_ctrl_assertions #(
    parameter bit IS_LEFT = 1'h1
) (
    input wire logic                     clk,
    input wire logic                     rst_n,
    input wire logic                     psel,
    input wire logic                     penable,
    input wire logic                     pwrite,
    input wire logic [11:0]              paddr,
    input wire logic [31:0]              pwdata,
    input wire logic [31:0]              prdata,
    input wire logic                     pready,
    input wire logic                     pslverr,
    input wire dpmc_pkg::dpmc_port_out_s port_o,
    input wire dpmc_pkg::dpmc_port_in_s  port_i,
    input wire logic [15:0]              data_i,
    input wire logic [15:0]              data_o,
    input wire logic [15:0]              data_oe,
    input wire logic                     mailbox_irq_n
);
    import dpmc_pkg::*;
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_n);
    // APB answer comes one cycle into the access phase, for one cycle
    chk_ready_answer: assert property (psel && penable && !pready |=> pready)
        else $error("pready late");
    chk_ready_single: assert property (pready |=> !pready)
        else $error("pready held");
    // Selects and address settle before the write strobe
    chk_setup_before: assert property ($fell(port_o.rd_wr_n) |->
        $past(!port_o.chip_en_n || !port_o.flag_space_select_n, 2)
        && $stable(port_o.addr)) else $error("strobe without setup");
    chk_write_width: assert property ($fell(port_o.rd_wr_n) |->
        !port_o.rd_wr_n [*6] ##1 port_o.rd_wr_n) else $error("write width");
    chk_read_width: assert property ($fell(port_o.out_en_n) |->
        !port_o.out_en_n [*6] ##1 port_o.out_en_n) else $error("read width");
    // Never drive the data bus while the memory drives it
    chk_no_contend: assert property (data_oe != 16'h0000 |-> port_o.out_en_n)
        else $error("bus contention");
    chk_one_space: assert property (
        port_o.chip_en_n || port_o.flag_space_select_n)
        else $error("both spaces selected");
    chk_strobe_selected: assert property (
        !port_o.rd_wr_n || !port_o.out_en_n |->
        !(port_o.chip_en_n && port_o.flag_space_select_n))
        else $error("strobe in standby");
    // Interrupt copy follows the pin one cycle later
    chk_irq_set: assert property (
        $fell(port_i.mailbox_irq_n) |=> !mailbox_irq_n)
        else $error("irq not raised");
    chk_irq_clear: assert property (
        $rose(port_i.mailbox_irq_n) |=> mailbox_irq_n)
        else $error("irq not cleared");
endmodule
bind dpmc_port_ctrl dpmc_port_ctrl_assertions #(.IS_LEFT(IS_LEFT)) u_chk (
    .clk(clk), .rst_n(rst_n), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .port_o(port_o), .port_i(port_i),
    .data_i(data_i), .data_o(data_o), .data_oe(data_oe),
    .mailbox_irq_n(mailbox_irq_n));

// ==== testbench/testbench.sv ====
// Self-checking bench for one left-port mailbox controller.
// Assumes the memory model stands in for the device; APB driven here.
`timescale 1ns/1ps
`include "dpmc_consts.svh"
module testbench;
    import dpmc_pkg::*;
    logic           clk = 1'h0, rst_n = 1'h0;
    logic           psel = 1'h0, penable = 1'h0, pwrite = 1'h0;
    logic [11:0]    paddr = 12'h000;
    logic [31:0]    pwdata = 32'h0, prdata, rd, st;
    logic           pready, pslverr, e, mailbox_irq_n, far_irq_n;
    logic           busy_n = 1'h1, far_wr = 1'h0, retry = 1'h0;
    logic [7:0]     far_req_n = 8'hFF;
    logic [15:0]    data_i, data_o, data_oe;
    logic [13:0]    ta [3];
    dpmc_port_out_s port_o;
    dpmc_port_in_s  port_i;
    int             err_count = 0, n_checks = 0;

    always #5 clk = ~clk;

    dpmc_port_ctrl #(.IS_LEFT(1'h1)) u_dpmc_port_ctrl (
        .clk(clk), .rst_n(rst_n), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .port_o(port_o),
        .port_i(port_i), .data_i(data_i), .data_o(data_o),
        .data_oe(data_oe), .mailbox_irq_n(mailbox_irq_n));
    dpmc_mem_model u_dpmc_mem_model (
        .clk(clk), .port_o(port_o), .data_o(data_o), .data_oe(data_oe),
        .busy_in_n(busy_n), .far_mbox_wr(far_wr), .far_req_n(far_req_n),
        .port_i(port_i), .data_i(data_i), .far_irq_n(far_irq_n));

    task chk(input string nm, input logic [31:0] ex, input logic [31:0] got);
        n_checks++;
        if (got !== ex) begin
            err_count++;
            $display("[ERR] %s expected %h seen %h", nm, ex, got);
        end
    endtask

    // One APB transfer; request held until pready at a rising edge
    task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        @(posedge clk);
        psel <= 1'h1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge clk);
        penable <= 1'h1;
        do @(posedge clk); while (pready !== 1'h1);
        rd = prdata;
        e = pslverr;
        psel <= 1'h0;
        penable <= 1'h0;
    endtask

    // Memory or flag access through the controller, waits for done
    task mem_op(input logic w, s, input logic [13:0] a, input logic [15:0] d);
        int n;
        apb(1'h1, `DPMC_OFF_ADDR, {18'h0, a});
        apb(1'h1, `DPMC_OFF_WDATA, {16'h0, d});
        apb(1'h1, `DPMC_OFF_CTRL, {28'h0, retry, s, w, 1'h1});
        n = 0;
        while (port_o.chip_en_n && port_o.flag_space_select_n && n < 20) begin
            @(posedge clk);
            n++;
        end
        do begin
            apb(1'h0, `DPMC_OFF_STATUS, 32'h0);
            st = rd;
        end while (st[`DPMC_ST_DONE] !== 1'h1);
        if (!w)
            apb(1'h0, `DPMC_OFF_RDATA, 32'h0);
    endtask

    task complete_run;
        $display("checks %0d mismatches %0d", n_checks, err_count);
        if (err_count == 0 && n_checks > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask

    // Watchdog well beyond the roughly 1400 cycles the tests need
    initial begin
        repeat (40000) @(posedge clk);
        err_count++;
        complete_run;
    end

    initial begin
        ta = '{14'h0123, `DPMC_MBOX_LEFT, `DPMC_MBOX_RIGHT};
        repeat (20) @(posedge clk);
        rst_n <= 1'h1;
        @(posedge clk);
        chk("chip_en_n", 32'h1, port_o.chip_en_n);
        chk("data_oe", 32'h0, data_oe);
        apb(1'h0, `DPMC_OFF_CTRL, 32'h0);
        chk("ctrl", `DPMC_CTRL_RST, rd);
        apb(1'h0, 12'h020, 32'h0);
        chk("pslverr", 32'h1, e);
        $display("test reset done");
        // A plain word and both mailbox words keep data
        for (int i = 0; i < 3; i++) begin
            mem_op(1'h1, 1'h0, ta[i], 16'hA5C3 ^ 16'(i));
            mem_op(1'h0, 1'h0, ta[i], 16'h0000);
            chk("mem", {16'h0, 16'hA5C3 ^ 16'(i)}, rd);
        end
        chk("far_irq_n", 32'h0, far_irq_n);
        far_wr <= 1'h1;
        @(posedge clk);
        far_wr <= 1'h0;
        repeat (3) @(posedge clk);
        chk("irq_n", 32'h0, mailbox_irq_n);
        apb(1'h0, `DPMC_OFF_STATUS, 32'h0);
        chk("st_irq", 32'h1, rd[`DPMC_ST_IRQ]);
        mem_op(1'h0, 1'h0, `DPMC_MBOX_LEFT, 16'h0000);
        repeat (3) @(posedge clk);
        chk("irq_n", 32'h1, mailbox_irq_n);
        $display("test mailbox done");
        // Busy low inhibits a write; retry waits it out
        mem_op(1'h1, 1'h0, 14'h0200, 16'h2222);
        busy_n <= 1'h0;
        mem_op(1'h1, 1'h0, 14'h0200, 16'h1111);
        chk("st_inhib", 32'h1, st[`DPMC_ST_INHIB]);
        busy_n <= 1'h1;
        mem_op(1'h0, 1'h0, 14'h0200, 16'h0000);
        chk("mem_kept", 32'h2222, rd);
        busy_n <= 1'h0;
        retry <= 1'h1;
        fork
            begin
                repeat (60) @(posedge clk);
                busy_n <= 1'h1;
            end
        join_none
        mem_op(1'h1, 1'h0, 14'h0200, 16'h1111);
        retry <= 1'h0;
        mem_op(1'h0, 1'h0, 14'h0200, 16'h0000);
        chk("mem_retry", 32'h1111, rd);
        $display("test busy done");
        // All flags: only bit 0 and low address bits count
        for (int i = 0; i < 8; i++) begin
            mem_op(1'h1, 1'h1, {11'h7FF, 3'(i)}, 16'hFFFE);
            mem_op(1'h0, 1'h1, {11'h7FF, 3'(i)}, 16'h0000);
            chk("sem_take", 32'h0000, rd);
            chk("sem_own", 32'h1, st[`DPMC_ST_SEMOWN]);
            mem_op(1'h1, 1'h1, {11'h000, 3'(i)}, 16'h0001);
            mem_op(1'h0, 1'h1, {11'h000, 3'(i)}, 16'h0000);
            chk("sem_free", 32'hFFFF, rd);
        end
        // Far side holds flag 5; our request waits until release
        far_req_n[5] <= 1'h0;
        mem_op(1'h1, 1'h1, 14'h0005, 16'h0000);
        mem_op(1'h0, 1'h1, 14'h0005, 16'h0000);
        chk("sem_pend", 32'hFFFF, rd);
        far_req_n[5] <= 1'h1;
        mem_op(1'h0, 1'h1, 14'h0005, 16'h0000);
        chk("sem_got", 32'h0000, rd);
        $display("test flags done");
        complete_run;
    end
endmodule

// ==== verilog/dpmc_apb_regs.sv ====
// APB slave holding the controller's own registers.
// Assumes one APB master, zero-wait answers, 32-bit aligned words.
`timescale 1ns/1ps
`include "dpmc_consts.svh"
module dpmc_apb_regs (
    input  wire logic        clk,
    input  wire logic        rst_n,
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [11:0] paddr,
    input  wire logic [31:0] pwdata,
    output logic      [31:0] prdata,
    output logic             pready,
    output logic             pslverr,
    output logic             go_pulse,
    output logic      [3:0]  ctrl,
    output logic      [13:0] addr,
    output logic      [15:0] wdata,
    input  wire logic [15:0] rdata,
    input  wire logic [4:0]  status
);
    import dpmc_pkg::*;

    logic [3:0]  ctrl_reg, ctrl_next;
    logic [13:0] addr_reg, addr_next;
    logic [15:0] wdata_reg, wdata_next;
    logic        go_reg, go_next;
    logic        wr_en, known;

    // Decode; unmapped offsets answer with an error
    always_comb begin
        wr_en      = psel && penable && pwrite;
        ctrl_next  = ctrl_reg;
        addr_next  = addr_reg;
        wdata_next = wdata_reg;
        go_next    = 1'b0;
        known      = 1'b1;
        prdata     = 32'h0000_0000;
        unique case (paddr)
            `DPMC_OFF_CTRL: begin
                prdata = {28'h0, ctrl_reg};
                if (wr_en) begin
                    ctrl_next = pwdata[3:0];
                    go_next   = pwdata[`DPMC_CTRL_GO];
                end
            end
            `DPMC_OFF_ADDR: begin
                prdata = {18'h0, addr_reg};
                if (wr_en) addr_next = pwdata[13:0];
            end
            `DPMC_OFF_WDATA: begin
                prdata = {16'h0, wdata_reg};
                if (wr_en) wdata_next = pwdata[15:0];
            end
            `DPMC_OFF_RDATA:  prdata = {16'h0, rdata};
            `DPMC_OFF_STATUS: prdata = {27'h0, status};
            default: known = 1'b0;
        endcase
    end

    // Register state; GO is a self-clearing strobe
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            ctrl_reg  <= 4'h0;
            addr_reg  <= 14'h0000;
            wdata_reg <= 16'h0000;
            go_reg    <= 1'b0;
        end else begin
            ctrl_reg  <= ctrl_next;
            addr_reg  <= addr_next;
            wdata_reg <= wdata_next;
            go_reg    <= go_next;
        end
    end

    assign pready   = 1'b1;
    assign pslverr  = psel && penable && !known;
    assign go_pulse = go_reg;
    assign ctrl     = ctrl_reg;
    assign addr     = addr_reg;
    assign wdata    = wdata_reg;
endmodule

// ==== verilog/dpmc_consts.svh ====
// Constants for the dual-port mailbox controller (one port of the memory).
// Assumes a 100 MHz clock and the pin timing of an asynchronous SRAM port.
`ifndef DPMC_CONSTS_SVH
`define DPMC_CONSTS_SVH
// Register byte offsets on the APB slave
`define DPMC_OFF_CTRL      12'h000
`define DPMC_OFF_ADDR      12'h004
`define DPMC_OFF_WDATA     12'h008
`define DPMC_OFF_RDATA     12'h00C
`define DPMC_OFF_STATUS    12'h010
// Control register fields
`define DPMC_CTRL_GO       0
`define DPMC_CTRL_WR       1
`define DPMC_CTRL_SEM      2
`define DPMC_CTRL_RETRY    3
// Status register fields
`define DPMC_ST_BUSY       0
`define DPMC_ST_IRQ        1
`define DPMC_ST_DONE       2
`define DPMC_ST_INHIB      3
`define DPMC_ST_SEMOWN     4
// Mailbox word addresses
`define DPMC_MBOX_LEFT     14'h3FFE
`define DPMC_MBOX_RIGHT    14'h3FFF
// Timing, ns, and derived cycle counts at 10 ns
`define DPMC_CLK_NS        10
`define DPMC_SETUP_NS      20
`define DPMC_STROBE_NS     60
`define DPMC_RECOV_NS      20
`define DPMC_SETUP_CYC  ((`DPMC_SETUP_NS + `DPMC_CLK_NS - 1) / `DPMC_CLK_NS)
`define DPMC_STROBE_CYC ((`DPMC_STROBE_NS + `DPMC_CLK_NS - 1) / `DPMC_CLK_NS)
`define DPMC_RECOV_CYC  ((`DPMC_RECOV_NS + `DPMC_CLK_NS - 1) / `DPMC_CLK_NS)
`define DPMC_CTRL_RST      32'h0000_0000
`endif

// ==== verilog/dpmc_data_pins.sv ====
// Two-way data pin splitter for the 16-bit memory bus.
// Assumes the caller holds output enable only while writing.
`timescale 1ns/1ps
module dpmc_data_pins (
    input  wire logic        clk,
    input  wire logic        rst_n,
    input  wire logic        drive,
    input  wire logic [15:0] wdata,
    input  wire logic        capture,
    input  wire logic [15:0] data_i,
    output logic      [15:0] data_o,
    output logic      [15:0] data_oe,
    output logic      [15:0] rdata
);
    import dpmc_pkg::*;

    logic [15:0] out_reg, out_next, oe_reg, oe_next, rd_reg, rd_next;

    // One lane per bit, so each enable can stand alone
    genvar b;
    generate
        for (b = 0; b < 16; b++) begin : g_lane
            always_comb begin
                out_next[b] = wdata[b];
                oe_next[b]  = drive;
                rd_next[b]  = capture ? data_i[b] : rd_reg[b];
            end
        end
    endgenerate

    // Registered so pins change only after a clock edge
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            out_reg <= 16'h0000;
            oe_reg  <= 16'h0000;
            rd_reg  <= 16'h0000;
        end else begin
            out_reg <= out_next;
            oe_reg  <= oe_next;
            rd_reg  <= rd_next;
        end
    end

    assign data_o  = out_reg;
    assign data_oe = oe_reg;
    assign rdata   = rd_reg;
endmodule

// ==== verilog/dpmc_pkg.sv ====
// Types for the dual-port mailbox controller.
// Assumes dpmc_consts.svh supplies the numbers.
package dpmc_pkg;
    typedef enum logic [2:0] {
        ST_IDLE, ST_SETUP, ST_STROBE, ST_RECOV, ST_DONE
    } dpmc_state_e;

    // Pins driven toward one memory port
    typedef struct packed {
        logic        chip_en_n;
        logic        flag_space_select_n;
        logic        rd_wr_n;
        logic        out_en_n;
        logic        high_byte_select_n;
        logic        low_byte_select_n;
        logic [13:0] addr;
    } dpmc_port_out_s;

    // Pins sampled from the memory port
    typedef struct packed {
        logic        busy_n;
        logic        mailbox_irq_n;
    } dpmc_port_in_s;

    typedef logic [15:0] dpmc_word_t;
endpackage

// ==== verilog/dpmc_port_ctrl.sv ====
// Host controller for one port of a two-port mailbox memory.
// Assumes software on APB; memory pins taken as synchronous to clk.
//
// Functional notes
// - Right side clears its interrupt by reading 3FFF.
// - Interrupts may be ignored and mailbox words used as storage.
// - Hold address and enable until busy settles, then strobe.
// - Only one master in a width-expanded array.
// - Depth-cascaded busy lines are ANDed per port.
// - Flags active low; write zero to request, one to release.
`timescale 1ns/1ps
`include "dpmc_consts.svh"
module dpmc_port_ctrl #(
    parameter bit IS_LEFT = 1'b1
) (
    input  wire logic                    clk,
    input  wire logic                    rst_n,
    input  wire logic                    psel,
    input  wire logic                    penable,
    input  wire logic                    pwrite,
    input  wire logic [11:0]             paddr,
    input  wire logic [31:0]             pwdata,
    output logic      [31:0]             prdata,
    output logic                         pready,
    output logic                         pslverr,
    output dpmc_pkg::dpmc_port_out_s     port_o,
    input  wire dpmc_pkg::dpmc_port_in_s port_i,
    input  wire logic [15:0]             data_i,
    output logic      [15:0]             data_o,
    output logic      [15:0]             data_oe,
    output logic                         mailbox_irq_n
);
    import dpmc_pkg::*;

    localparam logic [3:0] SETUP_C  = 4'(`DPMC_SETUP_CYC);
    localparam logic [3:0] STROBE_C = 4'(`DPMC_STROBE_CYC);
    localparam logic [3:0] RECOV_C  = 4'(`DPMC_RECOV_CYC);

    logic        go;
    logic [3:0]  ctrl;
    logic [13:0] addr;
    logic [15:0] wdata, rdata;
    logic [4:0]  status;
    logic [31:0] prdata_w;
    logic        pready_w, pslverr_w;

    dpmc_state_e    state_reg, state_next;
    logic [3:0]     cnt_reg, cnt_next;
    dpmc_port_out_s pins_reg, pins_next;
    logic           done_reg, done_next;
    logic           inhib_reg, inhib_next;
    logic           irq_reg, irq_next;
    logic           busy_seen_reg, busy_seen_next;
    logic           drive, capture;
    logic [31:0]    prdata_reg;
    logic           pready_reg, pslverr_reg, pready_next;
    logic           is_wr, is_sem;

    dpmc_apb_regs u_regs (
        .clk      (clk),
        .rst_n    (rst_n),
        .psel     (psel),
        .penable  (penable),
        .pwrite   (pwrite && pready_reg), // Write lands at the pready edge
        .paddr    (paddr),
        .pwdata   (pwdata),
        .prdata   (prdata_w),
        .pready   (pready_w),
        .pslverr  (pslverr_w),
        .go_pulse (go),
        .ctrl     (ctrl),
        .addr     (addr),
        .wdata    (wdata),
        .rdata    (rdata),
        .status   (status)
    );

    dpmc_data_pins u_data (
        .clk     (clk),
        .rst_n   (rst_n),
        .drive   (drive),
        .wdata   (wdata),
        .capture (capture),
        .data_i  (data_i),
        .data_o  (data_o),
        .data_oe (data_oe),
        .rdata   (rdata)
    );

    assign is_wr    = ctrl[`DPMC_CTRL_WR];
    assign is_sem   = ctrl[`DPMC_CTRL_SEM];

    // Registered answer: one pready per access phase, then it drops
    assign pready_next = pready_w && psel && penable && !pready_reg;

    // Access sequencer: setup, strobe, recovery, done
    always_comb begin
        state_next     = state_reg;
        cnt_next       = cnt_reg;
        pins_next      = pins_reg;
        done_next      = done_reg;
        inhib_next     = inhib_reg;
        busy_seen_next = busy_seen_reg;
        drive          = 1'b0;
        capture        = 1'b0;
        unique case (state_reg)
            ST_IDLE: begin
                // Both enables high: standby, nothing moves
                pins_next.chip_en_n           = 1'b1;
                pins_next.flag_space_select_n = 1'b1;
                pins_next.out_en_n            = 1'b1;
                pins_next.rd_wr_n             = 1'b1;
                if (go) begin
                    // Only A0-A2 matter for flags; upper bits zeroed
                    pins_next.addr = is_sem ? {11'h0, addr[2:0]} : addr;
                    pins_next.chip_en_n           = is_sem;
                    pins_next.flag_space_select_n = !is_sem;
                    pins_next.high_byte_select_n  = 1'b0;
                    pins_next.low_byte_select_n   = 1'b0;
                    done_next      = 1'b0;
                    inhib_next     = 1'b0;
                    busy_seen_next = 1'b0;
                    cnt_next       = SETUP_C;
                    state_next     = ST_SETUP;
                end
            end
            ST_SETUP: begin
                // Address and enable held until busy has settled
                cnt_next = cnt_reg - 4'h1;
                drive    = is_wr;
                if (cnt_reg == 4'h1) begin
                    // Flag accesses skip busy: no wait states
                    if (!is_sem && !port_i.busy_n) begin
                        busy_seen_next = 1'b1;
                        if (is_wr && !ctrl[`DPMC_CTRL_RETRY]) begin
                            // Write would be dropped inside anyway
                            inhib_next = 1'b1;
                        end
                    end
                    if (!is_sem && !port_i.busy_n &&
                        ctrl[`DPMC_CTRL_RETRY]) begin
                        // Busy with retry: stay in setup and recheck
                        cnt_next = SETUP_C;
                    end else begin
                        pins_next.rd_wr_n  = !is_wr;
                        pins_next.out_en_n = is_wr;
                        cnt_next   = STROBE_C;
                        state_next = ST_STROBE;
                    end
                end
            end
            ST_STROBE: begin
                cnt_next = cnt_reg - 4'h1;
                drive    = is_wr;
                if (cnt_reg == 4'h1) begin
                    // Capture at end of strobe; flag reads whole word
                    capture = !is_wr;
                    pins_next.rd_wr_n  = 1'b1;
                    pins_next.out_en_n = 1'b1;
                    cnt_next   = RECOV_C;
                    state_next = ST_RECOV;
                end
            end
            ST_RECOV: begin
                // Drop enables so a later flag read re-latches
                pins_next.chip_en_n           = 1'b1;
                pins_next.flag_space_select_n = 1'b1;
                cnt_next = cnt_reg - 4'h1;
                if (cnt_reg == 4'h1) begin
                    state_next = ST_DONE;
                end
            end
            ST_DONE: begin
                done_next  = 1'b1;
                state_next = ST_IDLE;
            end
            default: state_next = ST_IDLE;
        endcase
    end

    // Interrupt seen on the pin; clearing is a read of own mailbox
    always_comb begin
        irq_next = port_i.mailbox_irq_n;
    end

    // raise the far side's pin by a plain write to its mailbox
    // clear ours by a read of the own mailbox word from software.
    // mailbox data passes like any word.
    // are held by the memory and wiring; software writes 1/0.

    // Flag owned when a flag read returned zero
    assign status = {is_sem && !rdata[0],
                     inhib_reg, done_reg, !irq_reg, busy_seen_reg};

    // Registered state and top outputs
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            state_reg     <= ST_IDLE;
            cnt_reg       <= 4'h0;
            pins_reg      <= '{chip_en_n: 1'b1, flag_space_select_n: 1'b1,
                               rd_wr_n: 1'b1, out_en_n: 1'b1,
                               high_byte_select_n: 1'b1,
                               low_byte_select_n: 1'b1, addr: 14'h0000};
            done_reg      <= 1'b0;
            inhib_reg     <= 1'b0;
            irq_reg       <= 1'b1;
            busy_seen_reg <= 1'b0;
            prdata_reg    <= 32'h0000_0000;
            pready_reg    <= 1'b0;
            pslverr_reg   <= 1'b0;
        end else begin
            state_reg     <= state_next;
            cnt_reg       <= cnt_next;
            pins_reg      <= pins_next;
            done_reg      <= done_next;
            inhib_reg     <= inhib_next;
            irq_reg       <= irq_next;
            busy_seen_reg <= busy_seen_next;
            prdata_reg    <= prdata_w;
            pready_reg    <= pready_next;
            pslverr_reg   <= pslverr_w;
        end
    end

    assign port_o        = pins_reg;
    assign mailbox_irq_n = irq_reg;
    assign prdata        = prdata_reg;
    assign pready        = pready_reg;
    assign pslverr       = pslverr_reg;
endmodule
